//--- core/cci_cfg.svh
`ifndef CCI_CFG_SVH
`define CCI_CFG_SVH
// NMI vector type and vector table entry size
`define CCI_NMI_TYPE 8'h02
`define CCI_VEC_SHIFT 2
// Least reset hold in clock cycles
`define CCI_RST_HOLD_CYC 3'h4
`endif

//--- core/cci_pkg.sv
package cci_pkg;
  // Bus cycle states
  typedef enum logic [2:0] {
    CCI_TI,
    CCI_T1,
    CCI_T2,
    CCI_T3,
    CCI_TWAIT,
    CCI_T4
  } cci_bus_t;
  // Sequencer states
  typedef enum logic [2:0] {
    CCI_START,
    CCI_RUN,
    CCI_WAITTEST,
    CCI_ACK,
    CCI_VECTOR
  } cci_seq_t;
endpackage

//--- core/cci_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for one pin
module cci_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic pinIn,
  output logic pinSync
);
  logic meta_reg;
  logic sync_reg;
  // Second stage alone reads the first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
    end
  end
  assign pinSync = sync_reg;
endmodule // cci_sync

//--- core/cci_bus_seq.sv
`timescale 1ns/1ns
// Read bus cycle sequencer: T1 T2 T3 {wait} T4
module cci_bus_seq (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic memNotIo,
  input wire logic ready,
  output logic readStrobeN,
  output logic memIoSel,
  output logic waitState,
  output logic busy,
  output logic done
);
  cci_pkg::cci_bus_t st_reg;
  cci_pkg::cci_bus_t st_next;
  logic space_reg;
  // Next bus state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      cci_pkg::CCI_TI: begin
        if (start) begin
          st_next = cci_pkg::CCI_T1;
        end
      end
      cci_pkg::CCI_T1: st_next = cci_pkg::CCI_T2;
      cci_pkg::CCI_T2: st_next = cci_pkg::CCI_T3;
      // (R05) wait on ready
      cci_pkg::CCI_T3, cci_pkg::CCI_TWAIT: begin
        st_next = ready ? cci_pkg::CCI_T4 : cci_pkg::CCI_TWAIT;
      end
      cci_pkg::CCI_T4: st_next = cci_pkg::CCI_TI;
      default: st_next = cci_pkg::CCI_TI;
    endcase
  end
  // State and space latch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= cci_pkg::CCI_TI;
      space_reg <= 1'b1;
    end else if (ce) begin
      st_reg <= st_next;
      if (st_reg == cci_pkg::CCI_TI && start) begin
        space_reg <= memNotIo;
      end
    end
  end
  // (R01) strobe in T2 T3 waits
  assign readStrobeN = !(st_reg == cci_pkg::CCI_T2 || st_reg == cci_pkg::CCI_T3 ||
    st_reg == cci_pkg::CCI_TWAIT);
  // (R02) memory high io low
  assign memIoSel = space_reg;
  assign waitState = (st_reg == cci_pkg::CCI_TWAIT);
  assign busy = (st_reg != cci_pkg::CCI_TI);
  assign done = (st_reg == cci_pkg::CCI_T4);
endmodule // cci_bus_seq

//--- core/cci_control.sv
`timescale 1ns/1ns
`include "cci_cfg.svh"
// Overview of operation
// (R01) Read strobe low in T2, T3, waits
// (R02) Memory/IO select: memory high, IO low
// (R03) Addressed device raises ready to complete
// (R04) Clock generator synchronises raw ready
// (R05) Ready low at T3 inserts waits
// (R06) Maskable request level sampled at instruction end
// (R07) Maskable request ignored when enable clear
// (R08) Maskable request synchronised internally
// (R09) Accepted interrupt fetches vector from memory
// (R10) Wait instruction continues when test low
// (R11) Test input synchronised every clock
// (R12) Non-maskable edge sensitive, type two
// (R13) Non-maskable ignores enable flag
// (R14) Rising edge serviced after current instruction
// (R15) Non-maskable input synchronised internally
// (R16) Reset abandons activity at once
// (R17) Reset held high four clocks minimum
// (R18) Restart from start state after reset
// (R19) Reset passes through synchronisation
// (R20) Clock one third duty cycle
// (R21) Mode select tied statically
// (R22) Mode high minimum, low maximum
module cci_control (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic ready,
  input wire logic maskable_irq,
  input wire logic nmiPin,
  input wire logic testPinN,
  input wire logic bus_mode_select,
  input wire logic intEnable,
  input wire logic instrLast,
  input wire logic waitInstr,
  input wire logic readReq,
  input wire logic readMemNotIo,
  output logic readStrobeN,
  output logic memIoSel,
  output logic wait_state,
  output logic readDone,
  output logic intTaken,
  output logic [7:0] intType,
  output logic [9:0] vectorAddr,
  output logic vectorFetch,
  output logic execStall,
  output logic minMode,
  output logic resetActive
);
  ////////////////////////////////////////////////////////////////////////////
  logic rstMeta_reg;
  logic rstSync_reg;
  logic irqSync;
  logic nmiSync;
  logic testSync;
  logic nmiPrev_reg;
  logic nmiPend_reg;
  logic mode_reg;
  logic modeCaught_reg;
  logic [7:0] type_reg;
  logic taken_reg;
  logic fetch_reg;
  logic seqRst;
  logic nmiEdge;
  logic irqOk;
  logic takeInt;
  logic busStart;
  logic busMem;
  logic busDone;
  logic busBusy;
  cci_pkg::cci_seq_t seq_reg;
  cci_pkg::cci_seq_t seq_next;

  // Vector table entry address for a type
  function automatic logic [9:0] vecAddr(input logic [7:0] t);
    vecAddr = {t, 2'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // (R19) reset synchroniser stages
  always_ff @(posedge clk_sys) begin
    rstMeta_reg <= rst;
    rstSync_reg <= rstMeta_reg;
  end
  // (R16) abandon activity immediately
  assign seqRst = rst | rstSync_reg;
  assign resetActive = seqRst;

  ////////////////////////////////////////////////////////////////////////////
  // (R08) maskable request sync
  cci_sync uIrq (
    .clk_sys(clk_sys),
    .rst(seqRst),
    .ce(ce),
    .pinIn(maskable_irq),
    .pinSync(irqSync)
  );
  // (R15) non-maskable sync
  cci_sync uNmi (
    .clk_sys(clk_sys),
    .rst(seqRst),
    .ce(ce),
    .pinIn(nmiPin),
    .pinSync(nmiSync)
  );
  // (R11) test sync each clock
  // Synced as "test low" so its reset value means keep waiting
  cci_sync uTest (
    .clk_sys(clk_sys),
    .rst(seqRst),
    .ce(ce),
    .pinIn(~testPinN),
    .pinSync(testSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // (R12) rising edge detect
  assign nmiEdge = nmiSync & ~nmiPrev_reg;
  // (R07) mask by enable flag
  assign irqOk = irqSync & intEnable;
  // (R06) sample at instruction end
  // (R14) nmi waits for instruction end
  // Bus must be idle so the vector read can start at once
  assign takeInt = (seq_reg == cci_pkg::CCI_RUN) && instrLast && (nmiPend_reg | irqOk)
    && !busBusy;

  // NMI latch: a new edge wins over the clear on acceptance
  always_ff @(posedge clk_sys) begin
    if (seqRst) begin
      nmiPrev_reg <= 1'b0;
      nmiPend_reg <= 1'b0;
    end else if (ce) begin
      nmiPrev_reg <= nmiSync;
      // (R13) not gated by enable
      if (nmiEdge) begin
        nmiPend_reg <= 1'b1;
      end else if (takeInt) begin
        nmiPend_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // (R22) mode caught after reset release
  always_ff @(posedge clk_sys) begin
    if (seqRst) begin
      mode_reg <= 1'b1;
      modeCaught_reg <= 1'b0;
    end else if (ce && !modeCaught_reg) begin
      mode_reg <= bus_mode_select;
      modeCaught_reg <= 1'b1;
    end
  end
  assign minMode = mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      // (R18) restart from start state
      cci_pkg::CCI_START: seq_next = cci_pkg::CCI_RUN;
      cci_pkg::CCI_RUN: begin
        if (takeInt) begin
          seq_next = cci_pkg::CCI_ACK;
        end else if (waitInstr) begin
          seq_next = cci_pkg::CCI_WAITTEST;
        end
      end
      // (R10) idle until test low
      cci_pkg::CCI_WAITTEST: begin
        if (testSync) begin
          seq_next = cci_pkg::CCI_RUN;
        end
      end
      cci_pkg::CCI_ACK: seq_next = cci_pkg::CCI_VECTOR;
      // (R09) fetch vector from memory
      cci_pkg::CCI_VECTOR: begin
        if (busDone) begin
          seq_next = cci_pkg::CCI_RUN;
        end
      end
      default: seq_next = cci_pkg::CCI_START;
    endcase
  end

  // Sequencer and interrupt type registers
  always_ff @(posedge clk_sys) begin
    if (seqRst) begin
      seq_reg <= cci_pkg::CCI_START;
      type_reg <= 8'h00;
      taken_reg <= 1'b0;
      fetch_reg <= 1'b0;
    end else if (ce) begin
      seq_reg <= seq_next;
      taken_reg <= takeInt;
      fetch_reg <= (seq_reg == cci_pkg::CCI_ACK);
      if (takeInt) begin
        // (R12) nmi is type two
        type_reg <= nmiPend_reg ? `CCI_NMI_TYPE : 8'h00;
      end
    end
  end

  assign busStart = (seq_reg == cci_pkg::CCI_ACK) || (seq_reg == cci_pkg::CCI_RUN && readReq
    && !takeInt);
  assign busMem = (seq_reg == cci_pkg::CCI_ACK) ? 1'b1 : readMemNotIo;
  assign intTaken = taken_reg;
  assign intType = type_reg;
  assign vectorAddr = vecAddr(type_reg);
  assign vectorFetch = fetch_reg;
  assign execStall = (seq_reg != cci_pkg::CCI_RUN) || busBusy;
  assign readDone = busDone;

  ////////////////////////////////////////////////////////////////////////////
  // Read bus cycles
  cci_bus_seq uBus (
    .clk_sys(clk_sys),
    .rst(seqRst),
    .ce(ce),
    .start(busStart),
    .memNotIo(busMem),
    .ready(ready),
    .readStrobeN(readStrobeN),
    .memIoSel(memIoSel),
    .waitState(wait_state),
    .busy(busBusy),
    .done(busDone)
  );
endmodule // cci_control

//--- testbench/cci_control_asserts.sv
`timescale 1ns/1ns
// Protocol checks on the control block ports
module cci_control_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ready,
  input wire logic intEnable,
  input wire logic readStrobeN,
  input wire logic memIoSel,
  input wire logic wait_state,
  input wire logic readDone,
  input wire logic intTaken,
  input wire logic [7:0] intType,
  input wire logic [9:0] vectorAddr,
  input wire logic vectorFetch,
  input wire logic resetActive
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Strobe already low for a cycle: T3 or a wait
  sequence lateStrobe;
    !readStrobeN && $past(!readStrobeN);
  endsequence
  // Vector read follows the acceptance
  sequence vecRead;
    ##[1:3] vectorFetch ##[0:3] (!readStrobeN && memIoSel);
  endsequence
  wait_strobe_a: assert property (wait_state |-> !readStrobeN)
    else $error("strobe high in wait state");
  wait_insert_a: assert property (lateStrobe and !ready |=> wait_state)
    else $error("no wait state while not ready");
  ready_done_a: assert property (lateStrobe and ready |=> readDone && readStrobeN)
    else $error("transfer not ended by ready");
  sel_hold_a: assert property (lateStrobe |-> $stable(memIoSel))
    else $error("space select moved in transfer");
  vec_addr_a: assert property (intTaken |-> vectorAddr == {intType, 2'h0})
    else $error("vector address wrong");
  vec_fetch_a: assert property (intTaken |-> vecRead)
    else $error("no vector read after acceptance");
  irq_mask_a: assert property (intTaken && intType == 8'h00 |-> $past(intEnable))
    else $error("masked request taken");
  int_type_a: assert property (intTaken |-> intType inside {8'h00, 8'h02})
    else $error("unexpected interrupt type");
  reset_idle_a: assert property (resetActive |-> readStrobeN && !intTaken)
    else $error("activity during reset");
endmodule // cci_control_asserts

//--- testbench/cci_mem_model.sv
`timescale 1ns/1ns
// Memory or IO device answering reads after a set number of waits
module cci_mem_model (
  input wire logic clk_sys,
  input wire logic readStrobeN,
  input wire logic [3:0] waits,
  output logic ready
);
  logic [3:0] lowCnt_reg;
  // Count strobe-low cycles seen in this transfer
  always_ff @(posedge clk_sys) begin
    lowCnt_reg <= readStrobeN ? 4'h0 : lowCnt_reg + 4'h1;
  end
  // synchronous acknowledge, low when not selected
  assign ready = !readStrobeN && (lowCnt_reg > waits);
endmodule // cci_mem_model

//--- testbench/test_cpu_control_inputs.sv
`timescale 1ns/1ns
module test_cpu_control_inputs;
  logic clk_sys, rst, ce, ready, maskable_irq, nmiPin, testPinN, bus_mode_select;
  logic intEnable, instrLast, waitInstr, readReq, readMemNotIo, readStrobeN, memIoSel;
  logic wait_state, readDone, intTaken, vectorFetch, execStall, minMode, resetActive;
  logic [7:0] intType;
  logic [9:0] vectorAddr;
  logic [3:0] waits;
  int err_total, samples_checked, cycles;
  cci_control dut (.clk_sys, .rst, .ce, .ready, .maskable_irq, .nmiPin, .testPinN,
    .bus_mode_select, .intEnable, .instrLast, .waitInstr, .readReq, .readMemNotIo,
    .readStrobeN, .memIoSel, .wait_state, .readDone, .intTaken, .intType, .vectorAddr,
    .vectorFetch, .execStall, .minMode, .resetActive);
  cci_mem_model mem (.clk_sys, .readStrobeN, .waits, .ready);
  // 20 MHz clock, high for one third of the period
  initial begin
    clk_sys = 1'b0;
    forever begin
      #33 clk_sys = ~clk_sys;
      #17 clk_sys = ~clk_sys;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // One read with a given space and wait count
  task automatic do_read(input logic [9:0] mem, input logic [3:0] w);
    logic [9:0] lowN, waitN, sel;
    waits = w; readMemNotIo = mem[0]; readReq = 1'b1; cyc(1); readReq = 1'b0;
    lowN = 10'h0; waitN = 10'h0; sel = 10'h1;
    for (int i = 0; i < 20 && readDone !== 1'b1; i++) begin
      if (readStrobeN === 1'b0) begin
        lowN++;
        if (memIoSel !== mem[0]) sel = 10'h0;
      end
      if (wait_state === 1'b1) waitN++;
      cyc(1);
    end
    chk(readDone, 10'h1);
    chk(lowN, 10'h2 + w);
    chk(waitN, {6'h0, w});
    chk(sel, 10'h1);
    cyc(1);
  endtask
  // Interrupt request with enable setting
  task automatic do_int(input logic nmi, input logic en, input logic [9:0] tk, ty);
    logic [9:0] seenT, seenF, gotTy;
    seenT = 10'h0; seenF = 10'h0; gotTy = 10'h0;
    intEnable = en; nmiPin = nmi; maskable_irq = !nmi; instrLast = 1'b1;
    for (int i = 0; i < 14; i++) begin
      cyc(1);
      if (intTaken === 1'b1) begin
        seenT = 10'h1; gotTy = {2'h0, intType}; maskable_irq = 1'b0; nmiPin = 1'b0;
      end
      if (vectorFetch === 1'b1) seenF = 10'h1;
    end
    instrLast = 1'b0; maskable_irq = 1'b0; nmiPin = 1'b0;
    chk(seenT, tk);
    chk(gotTy, ty);
    chk(seenF, tk);
    cyc(4);
  endtask
  // Wait instruction held off by the test input
  task automatic do_wait();
    testPinN = 1'b1; waitInstr = 1'b1; cyc(1); waitInstr = 1'b0; cyc(4);
    chk(execStall, 10'h1);
    testPinN = 1'b0; ce = 1'b0; cyc(4);
    chk(execStall, 10'h1);
    ce = 1'b1; cyc(4);
    chk(execStall, 10'h0);
  endtask
  // Reset in mid-read, with a new mode strap
  task automatic do_reset(input logic mode);
    waits = 4'h8; readMemNotIo = 1'b1; readReq = 1'b1; cyc(1); readReq = 1'b0; cyc(2);
    // strap moves only while reset is held
    rst = 1'b1; bus_mode_select = mode; cyc(1);
    chk(readStrobeN, 10'h1);
    cyc(3); rst = 1'b0; cyc(1);
    chk(resetActive, 10'h1);
    cyc(3);
    chk(minMode, {9'h0, mode});
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence; reset held four cycles for the minimum
  initial begin
    rst = 1'b1; ce = 1'b1; maskable_irq = 1'b0; nmiPin = 1'b0; testPinN = 1'b1;
    bus_mode_select = 1'b1; intEnable = 1'b0; instrLast = 1'b0; waitInstr = 1'b0;
    readReq = 1'b0; readMemNotIo = 1'b1; waits = 4'h0;
    err_total = 0; samples_checked = 0; cycles = 0;
    cyc(4); rst = 1'b0; cyc(3);
    chk(minMode, 10'h1);
    do_read(10'h1, 4'h0);
    do_read(10'h0, 4'h2);
    do_int(1'b1, 1'b0, 10'h1, 10'h2);
    do_int(1'b0, 1'b0, 10'h0, 10'h0);
    do_int(1'b0, 1'b1, 10'h1, 10'h0);
    do_wait();
    do_reset(1'b0);
    do_read(10'h0, 4'h1);
    do_reset(1'b1);
    do_read(10'h1, 4'h0);
    close_out();
  end
endmodule // test_cpu_control_inputs
bind cci_control cci_control_asserts chk (.clk_sys, .rst, .ready, .intEnable, .readStrobeN,
  .memIoSel, .wait_state, .readDone, .intTaken, .intType, .vectorAddr, .vectorFetch,
  .resetActive);
